// ---- hw/rst_ctrl_pkg.sv ----
// Constants, register map and types of the system reset controller.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package rst_ctrl_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS    = 25000;
   localparam int unsigned PIN_MIN_PULSE_NS = 2500;
   localparam int unsigned PIN_MIN_CYCLES_I =
      (PIN_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PIN_CNT_W        = 8;
   localparam logic [PIN_CNT_W-1:0] PIN_MIN_CYCLES = PIN_CNT_W'(PIN_MIN_CYCLES_I);

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned ADR_W        = 8;
   localparam logic [ADR_W-1:0] CAUSE_OFS    = 8'h00;
   localparam logic [ADR_W-1:0] IRQ_STAT_OFS = 8'h04;
   localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 8'h08;
   localparam logic [ADR_W-1:0] STATE_OFS    = 8'h0c;

   // ----------------------------------------------------------------
   // Source and flag bit positions
   // ----------------------------------------------------------------
   localparam int unsigned SRC_N       = 4;
   localparam int unsigned POR_BIT     = 0;
   localparam int unsigned PIN_BIT     = 1;
   localparam int unsigned BOD_BIT     = 2;
   localparam int unsigned WDT_BIT     = 3;
   localparam int unsigned SYNC_N      = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [SRC_N-1:0]  CAUSE_RST    = 4'h0;
   localparam logic [SRC_N-1:0]  POR_ONLY     = 4'h1;
   localparam logic [SRC_N-1:0]  IRQ_STAT_RST = 4'h0;
   localparam logic [SRC_N-1:0]  IRQ_MASK_RST = 4'h0;
   localparam logic [SYNC_N-1:0] SYNC_RST     = 3'h0;
   localparam logic [15:0]       RESET_VECTOR = 16'h0000;

   // ----------------------------------------------------------------
   // Stretch length coding
   // ----------------------------------------------------------------
   localparam int unsigned SUT_W        = 2;
   localparam int unsigned CLOCK_SOURCE_FUSE_W      = 4;
   localparam int unsigned CLOCK_SOURCE_FUSE_SHIFT  = 4;

   typedef enum logic [1:0] {PH_HOLD, PH_STRETCH, PH_RUN} phase_t;

endpackage : rst_ctrl_pkg

// ---- hw/io_rst_if.sv ----
// Link between the reset sequencer and the clockless port reset keeper.
// Assumes the raw source term is formed combinationally from the pins.
`timescale 1ns/1ps
interface io_rst_if;
   logic raw_src;
   logic hold;
   logic io_reset;

   modport ctrl   (output raw_src, output hold, input io_reset);
   modport keeper (input raw_src, input hold, output io_reset);
endinterface : io_rst_if

// ---- hw/io_reset_keeper.sv ----
// Port reset flop: set at once by a raw reset source, no clock needed.
// Assumes the sequencer drives hold low only when internal reset ends.
`timescale 1ns/1ps
module io_reset_keeper
(
   input  logic         clk_i,
   input  logic         rst_i,
   io_rst_if.keeper     link
);

   // ----------------------------------------------------------------
   // Asynchronous set, synchronous release
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge link.raw_src)
   begin
      if (link.raw_src)
         link.io_reset <= 1'b1;
      else if (rst_i)
         link.io_reset <= 1'b1;
      else
         link.io_reset <= link.hold;
   end

endmodule : io_reset_keeper

// ---- hw/system_reset_controller.sv ----
// System reset controller: four reset sources, stretch counter, cause flags.
// Assumes fuses and watchdog signals are on clk_i; supply and pin inputs are not.
//
// Operation
// - Internal reset forces I/O state, then start vector
// - Port reset asserts instantly without any clock; a watchdog reset sets it on the clock edge with internal reset
// - After all sources release, count then release
// - Stretch length chosen by startup and clock fuses
// - Four sources; any active asserts internal reset
// - Power-on reset held while supply stays low
// - Pin low beyond minimum width resets device
// - Watchdog resets only in system-reset mode
// - Brown-out resets only while detector enabled
// - Supply reaching threshold starts the stretch count
// - Supply drop reasserts port reset with no delay; internal reset follows after the synchronisers
// - Power-on reset armed only after seeing low
// - Watchdog pulse one cycle; count starts after
// - Cause flags set by source, cleared by POR/zero
// - Power-on flag cleared only by zero write
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
module system_reset_controller
   import rst_ctrl_pkg::*;
#(
   parameter int unsigned CNT_W        = 24,
   parameter int unsigned STRETCH_BASE = 64
)
(
   input  logic                 clk_i,
   input  logic                 rst_i,
   input  logic                 wb_cyc_i,
   input  logic                 wb_stb_i,
   input  logic                 wb_we_i,
   input  logic [ADR_W-1:0]     wb_adr_i,
   input  logic [3:0]           wb_sel_i,
   input  logic [31:0]          wb_dat_i,
   output logic [31:0]          wb_dat_o,
   output logic                 wb_ack_o,
   input  logic                 por_low_i,
   input  logic                 reset_pin_n_i,
   input  logic                 bod_enable_i,
   input  logic                 bod_low_i,
   input  logic                 wdt_timeout_i,
   input  logic                 wdt_reset_mode_i,
   input  logic [SUT_W-1:0]     startup_time_fuse_i,
   input  logic [CLOCK_SOURCE_FUSE_W-1:0]   clock_source_fuse_i,
   output logic                 sys_rst_o,
   output logic                 io_reset_o,
   output logic                 cpu_start_o,
   output logic [15:0]          boot_addr_o,
   output logic                 irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SYNC_N-1:0]    sync1;
      logic [SYNC_N-1:0]    sync2;
      logic [SYNC_N-1:0]    sync3;
      logic [SYNC_N-1:0]    filt;
      logic                 por_armed;
      logic [PIN_CNT_W-1:0] pin_cnt;
      logic                 wdt_pulse;
      logic [SRC_N-1:0]     act;
      phase_t               phase;
      logic [CNT_W-1:0]     cnt;
      logic                 sys_rst;
      logic                 start;
      logic [15:0]          boot_addr;
      logic [SRC_N-1:0]     cause;
      logic [SRC_N-1:0]     irq_stat;
      logic [SRC_N-1:0]     irq_mask;
      logic                 irq;
      logic                 ack;
      logic [31:0]          rdat;
   } state_t;

   state_t q;
   state_t d;

   io_rst_if link ();

   // ----------------------------------------------------------------
   // Stretch length decode
   // ----------------------------------------------------------------
   function automatic logic [CNT_W-1:0] stretch_len
   (
      input logic [SUT_W-1:0]   startup_time_fuse,
      input logic [CLOCK_SOURCE_FUSE_W-1:0] clock_source_fuse
   );
      logic [CNT_W-1:0] base;
      logic [CNT_W-1:0] extra;
      base  = CNT_W'(STRETCH_BASE) << (2 * startup_time_fuse);
      extra = CNT_W'(clock_source_fuse) << CLOCK_SOURCE_FUSE_SHIFT;
      return CNT_W'(base + extra);
   endfunction : stretch_len

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic             por_low_f;
   logic             pin_low_f;
   logic             bod_low_f;
   logic [SRC_N-1:0] src;
   logic             any_src;
   logic             req;
   logic             wr;
   logic [SRC_N-1:0] wlow;
   logic [SRC_N-1:0] rise;

   always_comb
   begin
      d = q;

      // Three-stage input synchronisers
      d.sync1 = {bod_low_i, ~reset_pin_n_i, por_low_i};
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      d.filt  = (~(q.sync2 ^ q.sync3) & q.sync3) | ((q.sync2 ^ q.sync3) & q.filt);

      por_low_f = q.filt[POR_BIT];
      pin_low_f = q.filt[PIN_BIT];
      bod_low_f = q.filt[BOD_BIT];

      // Power-on detector
      d.por_armed = q.por_armed | por_low_f;

      // Pin low width filter
      if (!pin_low_f)
         d.pin_cnt = '0;
      else if (q.pin_cnt != PIN_MIN_CYCLES)
         d.pin_cnt = PIN_CNT_W'(q.pin_cnt + 1'b1);

      // Watchdog one-cycle reset pulse
      d.wdt_pulse = wdt_timeout_i & wdt_reset_mode_i;

      // Source vector
      src          = '0;
      src[POR_BIT] = por_low_f & q.por_armed;
      src[PIN_BIT] = pin_low_f & (q.pin_cnt == PIN_MIN_CYCLES);
      src[BOD_BIT] = bod_enable_i & bod_low_f;
      src[WDT_BIT] = q.wdt_pulse;
      any_src      = |src;
      d.act        = src;
      rise         = src & ~q.act;

      // Sequencer
      d.start = 1'b0;
      case (q.phase)
         PH_RUN:
         begin
            if (any_src)
               d.phase = PH_HOLD;
         end
         PH_HOLD:
         begin
            if (!any_src)
            begin
               d.phase = PH_STRETCH;
               d.cnt   = stretch_len(startup_time_fuse_i, clock_source_fuse_i);
            end
         end
         PH_STRETCH:
         begin
            if (any_src)
               d.phase = PH_HOLD;
            else if (q.cnt == '0)
            begin
               d.phase = PH_RUN;
               d.start = 1'b1;
            end
            else
               d.cnt = CNT_W'(q.cnt - 1'b1);
         end
         default:
         begin
            d.phase = PH_HOLD;
         end
      endcase
      d.sys_rst   = (d.phase != PH_RUN);
      d.boot_addr = RESET_VECTOR;

      // Bus decode
      req    = wb_cyc_i & wb_stb_i & ~q.ack;
      wr     = req & wb_we_i & wb_sel_i[0];
      wlow   = wb_dat_i[SRC_N-1:0];
      d.ack  = req;
      d.rdat = '0;

      // Reset cause flags: clear by zero write, set wins
      if (wr && wb_adr_i == CAUSE_OFS)
         d.cause = q.cause & wlow;
      d.cause = d.cause | src;
      if (src[POR_BIT])
         d.cause = POR_ONLY;

      // Interrupt status, write one to clear, set wins
      if (wr && wb_adr_i == IRQ_STAT_OFS)
         d.irq_stat = q.irq_stat & ~wlow;
      d.irq_stat = d.irq_stat | rise;
      if (wr && wb_adr_i == IRQ_MASK_OFS)
         d.irq_mask = wlow;
      d.irq = |(d.irq_stat & d.irq_mask);

      // Read data
      if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            CAUSE_OFS:    d.rdat = {28'h0, q.cause};
            IRQ_STAT_OFS: d.rdat = {28'h0, q.irq_stat};
            IRQ_MASK_OFS: d.rdat = {28'h0, q.irq_mask};
            STATE_OFS:    d.rdat = {24'h0, q.phase, q.sys_rst, q.por_armed, 1'b0, q.filt};
            default:      d.rdat = '0;
         endcase
      end

      // Synchronous reset of the controller itself
      if (rst_i)
      begin
         d.sync1     = SYNC_RST;
         d.sync2     = SYNC_RST;
         d.sync3     = SYNC_RST;
         d.filt      = SYNC_RST;
         d.por_armed = 1'b0;
         d.pin_cnt   = '0;
         d.wdt_pulse = 1'b0;
         d.act       = '0;
         d.phase     = PH_STRETCH;
         d.cnt       = stretch_len(startup_time_fuse_i, clock_source_fuse_i);
         d.sys_rst   = 1'b1;
         d.start     = 1'b0;
         d.boot_addr = RESET_VECTOR;
         d.cause     = CAUSE_RST;
         d.irq_stat  = IRQ_STAT_RST;
         d.irq_mask  = IRQ_MASK_RST;
         d.irq       = 1'b0;
         d.ack       = 1'b0;
         d.rdat      = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      q <= d;
   end

   // ----------------------------------------------------------------
   // Clockless port reset
   // ----------------------------------------------------------------
   assign link.raw_src = por_low_i | ~reset_pin_n_i | (bod_enable_i & bod_low_i);
   assign link.hold    = d.sys_rst;

   io_reset_keeper u_keeper
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .link  (link.keeper)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_o    = q.rdat;
   assign wb_ack_o    = q.ack;
   assign sys_rst_o   = q.sys_rst;
   assign io_reset_o  = link.io_reset;
   assign cpu_start_o = q.start;
   assign boot_addr_o = q.boot_addr;
   assign irq_o       = q.irq;

endmodule : system_reset_controller

// ---- verif/rst_ctrl_monitor.sv ----
// Port checker of the system reset controller.
// Assumes a bind to the top module, stretch base handed on.
`timescale 1ns/1ps
module rst_ctrl_monitor
   import rst_ctrl_pkg::*;
#(
   parameter int unsigned STRETCH_BASE = 64
)
(
   input logic         clk_i,
   input logic         rst_i,
   input logic         wb_cyc_i,
   input logic         wb_stb_i,
   input logic         wb_ack_o,
   input logic [31:0]  wb_dat_o,
   input logic         por_low_i,
   input logic         reset_pin_n_i,
   input logic         bod_enable_i,
   input logic         bod_low_i,
   input logic [1:0]   startup_time_fuse_i,
   input logic [3:0]   clock_source_fuse_i,
   input logic         sys_rst_o,
   input logic         io_reset_o,
   input logic         cpu_start_o,
   input logic [15:0]  boot_addr_o
);
   // ---------------------------------------------
   // Cycles of internal reset
   // ---------------------------------------------
   logic [31:0] hi_q;
   int unsigned len;
   assign len = (STRETCH_BASE << (2 * startup_time_fuse_i)) + (32'(clock_source_fuse_i) << 4);
   always_ff @(posedge clk_i)
      hi_q <= (rst_i || !sys_rst_o) ? 32'h0 : hi_q + 32'h1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
   a_io_set: assert property (por_low_i || !reset_pin_n_i || (bod_enable_i && bod_low_i)
      |-> io_reset_o) else $error("port reset");
   a_start_fall: assert property (cpu_start_o |-> !sys_rst_o && $past(sys_rst_o))
      else $error("start pulse");
   a_boot_vec: assert property (cpu_start_o |-> boot_addr_o == RESET_VECTOR)
      else $error("boot address");
   a_stretch_len: assert property ($fell(sys_rst_o) |-> hi_q > len)
      else $error("stretch short");
   a_io_release: assert property ($fell(io_reset_o) |-> !sys_rst_o)
      else $error("port release");
   a_por_hold: assert property (por_low_i [*8] |-> sys_rst_o) else $error("power-on");
   a_bod_hold: assert property ((bod_enable_i && bod_low_i) [*8] |-> sys_rst_o)
      else $error("brown-out");
endmodule : rst_ctrl_monitor
bind system_reset_controller rst_ctrl_monitor #(.STRETCH_BASE(STRETCH_BASE)) mon_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .por_low_i, .reset_pin_n_i,
   .bod_enable_i, .bod_low_i, .startup_time_fuse_i, .clock_source_fuse_i, .sys_rst_o,
   .io_reset_o, .cpu_start_o, .boot_addr_o);

// ---- verif/supply_partner.sv ----
// Model of the reset pin driver and the supply detectors.
// Assumes lines change just after a rising clock edge.
`timescale 1ns/1ps
module supply_partner
(
   input  logic clk_i,
   output logic por_low_o,
   output logic reset_pin_n_o,
   output logic bod_low_o
);
   logic [2:0] act_q = 3'h0;
   assign por_low_o     = act_q[0];
   assign reset_pin_n_o = !act_q[1];
   assign bod_low_o     = act_q[2];
   // Holds one line active for n cycles
   task automatic hold(input int sel, input int n);
      @(posedge clk_i);
      act_q[sel] <= 1'b1;
      repeat (n) @(posedge clk_i);
      act_q[sel] <= 1'b0;
   endtask : hold
endmodule : supply_partner

// ---- verif/system_reset_controller_tb.sv ----
// Self-checking bench of the system reset controller.
// Assumes a 40 MHz clock and a short stretch base.
`timescale 1ns/1ps
module system_reset_controller_tb;
   import rst_ctrl_pkg::*;
   localparam int unsigned SB = 4;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bod_en = 0, wdt_to = 0, wdt_mode = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0, clock_source_fuse = 0;
   logic [1:0] startup_time_fuse = 0;
   logic [31:0] dat = 0, rd, wb_dat_o;
   logic wb_ack_o, por_low, pin_n, bod_low, sys_rst_o, io_reset_o, cpu_start_o, irq_o, saw;
   logic [15:0] boot_addr_o;
   int n_fail = 0, checks = 0, exp_cause = 0, exp_stat = 0, s, c;
   system_reset_controller #(.STRETCH_BASE(SB)) system_reset_controller_inst (.clk_i, .rst_i,
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .por_low_i(por_low), .reset_pin_n_i(pin_n),
      .bod_enable_i(bod_en), .bod_low_i(bod_low), .wdt_timeout_i(wdt_to),
      .wdt_reset_mode_i(wdt_mode), .startup_time_fuse_i(startup_time_fuse), .clock_source_fuse_i(clock_source_fuse),
      .sys_rst_o, .io_reset_o, .cpu_start_o, .boot_addr_o, .irq_o);
   supply_partner supply_partner_inst (.clk_i, .por_low_o(por_low), .reset_pin_n_o(pin_n),
      .bod_low_o(bod_low));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (sys_rst_o) saw = 1;
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
      if (n >= 20) n_fail++;
      rd = wb_dat_o;
      {cyc, stb} <= 2'b00;
   endtask : wb
   task automatic settle(input int exp_n);
      int n;
      n = 0;
      do @(posedge clk_i); while (sys_rst_o !== 1'b0 && ++n < 6000);
      check(cpu_start_o, 1);
      check(boot_addr_o, RESET_VECTOR);
      if (exp_n > 0) check(n, exp_n);
   endtask : settle
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial
   begin
      void'($urandom(32'h03a79fdb));
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      settle(SB + 1);
      for (int i = 0; i < 3; i++)
      begin
         s = $urandom % 2;
         c = $urandom % 4;
         startup_time_fuse <= 2'(s);
         clock_source_fuse <= 4'(c);
         rst_i <= 1;
         repeat (4) @(posedge clk_i);
         rst_i <= 0;
         settle((SB << (2 * s)) + (c << 4) + 1);
      end
      $display("Test stretch done");
      fork
         supply_partner_inst.hold(0, 20);
         begin
            @(posedge clk_i);
            #1 check(io_reset_o, 1);
         end
      join
      settle(0);
      exp_cause = 1;
      exp_stat = 1;
      for (int k = 1; k < 4; k++)
         for (int on = 0; on < 2; on++)
         begin
            saw = 0;
            bod_en <= k == 2 && on == 1;
            wdt_mode <= k == 3 && on == 1;
            if (k < 3) supply_partner_inst.hold(k, (k == 1 && on == 0) ? 50 : 120);
            else
            begin
               @(posedge clk_i) wdt_to <= 1;
               @(posedge clk_i) wdt_to <= 0;
               repeat (2) @(posedge clk_i);
            end
            if (on == 1) settle(0);
            else repeat (20) @(posedge clk_i);
            if (on == 0) check(saw, 0);
            exp_cause |= on << k;
            exp_stat |= on << k;
            wb(0, CAUSE_OFS, 0);
            check(rd, exp_cause);
         end
      $display("Test sources done");
      wb(0, IRQ_STAT_OFS, 0);
      check(rd, exp_stat);
      wb(1, IRQ_MASK_OFS, 32'h4);
      repeat (2) @(posedge clk_i);
      check(irq_o, 1);
      wb(1, IRQ_STAT_OFS, 32'h4);
      repeat (2) @(posedge clk_i);
      check(irq_o, 0);
      wb(0, IRQ_STAT_OFS, 0);
      check(rd, exp_stat & 32'hb);
      wb(1, CAUSE_OFS, 32'hfe);
      wb(0, CAUSE_OFS, 0);
      check(rd, 32'he);
      supply_partner_inst.hold(0, 20);
      settle(0);
      wb(0, CAUSE_OFS, 0);
      check(rd, 32'h1);
      wb(0, 8'h20, 0);
      check(rd, 0);
      $display("Test registers done");
      report_and_stop();
   end
   initial
   begin
      #2000000;
      n_fail++;
      report_and_stop();
   end
endmodule : system_reset_controller_tb
